/* qodr_read.sv */
// read-command slave: quad-output and dual-io reads with continuous mode
// assumes mem_data answers mem_addr within a few clk cycles
`timescale 1ns/1ps
module qodr_read (
  input  wire logic                               clk,
  input  wire logic                               reset_n,
  input  wire logic                               sck,
  input  wire logic                               cs_n,
  input  wire logic [3:0]                         io_in,
  output logic [3:0]                              io_out,
  output logic [3:0]                              io_oe,
  input  wire logic                               quad_enable,
  input  wire logic [1:0]                         latency_code,
  input  wire logic                               extended_address_enable,
  input  wire logic                               high_perf_variant,
  output logic [qodr_pkg::MEM_ADDR_W-1:0]         mem_addr,
  input  wire logic [7:0]                         mem_data,
  output logic                                    continuous_active
);

  logic        sck_rise;
  logic        sck_fall;
  logic        cs_rise;
  logic        cs_fall;
  logic [3:0]  io_s;

  qodr_sync u_sync (
    .clk      (clk),
    .reset_n  (reset_n),
    .sck      (sck),
    .cs_n     (cs_n),
    .io_in    (io_in),
    .sck_rise (sck_rise),
    .sck_fall (sck_fall),
    .cs_rise  (cs_rise),
    .cs_fall  (cs_fall),
    .io_s     (io_s)
  );

  qodr_pkg::qodr_state_t          state_q, state_d;
  logic [5:0]                     cnt_q, cnt_d;
  logic [5:0]                     addr_len_q, addr_len_d;
  logic [5:0]                     left_q, left_d;
  logic [3:0]                     rises_q, rises_d;
  logic [7:0]                     cmd_q, cmd_d;
  logic [31:0]                    addr_q, addr_d;
  logic [7:0]                     mode_q, mode_d;
  logic [7:0]                     sh_q, sh_d;
  logic [1:0]                     part_q, part_d;
  logic                           dual_q, dual_d;
  logic                           mode_done_q, mode_done_d;
  logic                           mode_hit_q, mode_hit_d;
  logic                           cont_q, cont_d;
  logic [3:0]                     out_q, out_d;
  logic [3:0]                     oe_q, oe_d;
  logic [qodr_pkg::MEM_ADDR_W-1:0] maddr_q, maddr_d;

  logic [7:0]  cmd_full;
  logic [31:0] addr_full;
  logic [7:0]  mode_full;
  logic [7:0]  byte_now;
  logic        drive;

  // one next-state block for the whole transaction; rise and fall never coincide
  always_comb begin
    state_d     = state_q;
    cnt_d       = cnt_q;
    addr_len_d  = addr_len_q;
    left_d      = left_q;
    rises_d     = rises_q;
    cmd_d       = cmd_q;
    addr_d      = addr_q;
    mode_d      = mode_q;
    sh_d        = sh_q;
    part_d      = part_q;
    dual_d      = dual_q;
    mode_done_d = mode_done_q;
    mode_hit_d  = mode_hit_q;
    cont_d      = cont_q;
    out_d       = out_q;
    oe_d        = oe_q;
    maddr_d     = maddr_q;
    cmd_full    = {cmd_q[6:0], io_s[0]};
    addr_full   = dual_q ? {addr_q[29:0], io_s[1], io_s[0]} : {addr_q[30:0], io_s[0]};
    mode_full   = {mode_q[5:0], io_s[1], io_s[0]};
    byte_now    = (part_q == 2'h0) ? mem_data : sh_q;
    drive       = ((state_q == qodr_pkg::QODR_DUMMY) && (left_q == 6'h00)) ||
                  (state_q == qodr_pkg::QODR_DATA);
    if (cs_rise) begin
      // deselect ends any phase and releases the pins at once
      state_d = qodr_pkg::QODR_IDLE; // R19
      oe_d    = qodr_pkg::OE_NONE; // R19
      if (rises_q <= qodr_pkg::SHORT_SELECT_MAX) begin
        cont_d = 1'b0; // R12
      end else if (mode_done_q) begin
        cont_d = mode_hit_q; // R10 R11
      end else if (state_q == qodr_pkg::QODR_MODE) begin
        cont_d = 1'b0; // R15
      end
    end else if (cs_fall) begin
      // continuous mode skips the instruction and reuses the last width
      state_d     = cont_q ? qodr_pkg::QODR_ADDR : qodr_pkg::QODR_CMD; // R10
      cnt_d       = 6'h00;
      rises_d     = 4'h0;
      addr_d      = 32'h0000_0000;
      part_d      = 2'h0;
      mode_done_d = 1'b0;
      mode_hit_d  = 1'b0;
    end else if (sck_rise && (state_q != qodr_pkg::QODR_IDLE)) begin
      if (rises_q != qodr_pkg::RISE_COUNT_SAT) begin
        rises_d = rises_q + 4'h1;
      end
      case (state_q)
        qodr_pkg::QODR_CMD: begin
          cmd_d = cmd_full; // R17
          cnt_d = cnt_q + 6'h01;
          if (cnt_q == qodr_pkg::CMD_BITS - 6'h01) begin
            cnt_d   = 6'h00;
            state_d = qodr_pkg::QODR_ADDR;
            case (cmd_full)
              qodr_pkg::QUAD_OUTPUT_READ_CMD: begin
                dual_d     = 1'b0;
                addr_len_d = extended_address_enable ? qodr_pkg::ADDR_BITS_WIDE
                                                     : qodr_pkg::ADDR_BITS_NARROW; // R1 R18
                if (!quad_enable) begin
                  state_d = qodr_pkg::QODR_IGNORE; // R5
                end
              end
              qodr_pkg::QUAD_OUTPUT_READ_WIDE_ADDR_CMD: begin
                dual_d     = 1'b0;
                addr_len_d = qodr_pkg::ADDR_BITS_WIDE; // R1
                if (!quad_enable) begin
                  state_d = qodr_pkg::QODR_IGNORE; // R5
                end
              end
              qodr_pkg::DUAL_IO_READ_CMD: begin
                dual_d     = 1'b1;
                addr_len_d = (extended_address_enable ? qodr_pkg::ADDR_BITS_WIDE
                                                      : qodr_pkg::ADDR_BITS_NARROW) >> 1; // R6 R18
              end
              qodr_pkg::DUAL_IO_READ_WIDE_ADDR_CMD: begin
                dual_d     = 1'b1;
                addr_len_d = qodr_pkg::ADDR_BITS_WIDE >> 1; // R6
              end
              default: begin
                state_d = qodr_pkg::QODR_IGNORE;
              end
            endcase
          end
        end
        qodr_pkg::QODR_ADDR: begin
          addr_d = addr_full; // R7 R20
          cnt_d  = cnt_q + 6'h01;
          if (cnt_q == addr_len_q - 6'h01) begin
            cnt_d   = 6'h00;
            maddr_d = addr_full[qodr_pkg::MEM_ADDR_W-1:0];
            if (dual_q && !high_perf_variant) begin
              state_d = qodr_pkg::QODR_MODE; // R9
            end else begin
              state_d = qodr_pkg::QODR_DUMMY; // R3 R8
              left_d  = qodr_pkg::qodr_dummy(latency_code, 1'b0); // R16
            end
          end
        end
        qodr_pkg::QODR_MODE: begin
          mode_d = mode_full;
          cnt_d  = cnt_q + 6'h01;
          if (cnt_q == qodr_pkg::MODE_CYCLES - 6'h01) begin
            cnt_d       = 6'h00;
            mode_done_d = 1'b1;
            mode_hit_d  = (mode_full[7:4] == qodr_pkg::CONT_NIBBLE); // R10 R11
            state_d     = qodr_pkg::QODR_DUMMY;
            left_d      = qodr_pkg::qodr_dummy(latency_code, 1'b1); // R9 R16
          end
        end
        default: begin
        end
      endcase
    end else if (sck_fall) begin
      if ((state_q == qodr_pkg::QODR_DUMMY) && (left_q != 6'h00)) begin
        left_d = left_q - 6'h01; // R3
      end
      // data leaves on falling edges, high bits of each byte first
      if (drive) begin
        state_d = qodr_pkg::QODR_DATA;
        part_d  = part_q + 2'h1;
        if (dual_q) begin
          out_d = {2'h0, byte_now[7:6]}; // R14
          sh_d  = {byte_now[5:0], 2'h0};
          oe_d  = qodr_pkg::OE_DUAL; // R13
        end else begin
          out_d = byte_now[7:4]; // R2
          sh_d  = {byte_now[3:0], 4'h0};
          oe_d  = qodr_pkg::OE_QUAD; // R13
        end
        if (part_q == (dual_q ? 2'h3 : 2'h1)) begin
          part_d  = 2'h0;
          maddr_d = maddr_q + 1'b1; // R4
        end
      end
    end
  end

  // registers of the transaction engine
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q     <= qodr_pkg::QODR_IDLE;
      cnt_q       <= 6'h00;
      addr_len_q  <= qodr_pkg::ADDR_BITS_NARROW;
      left_q      <= 6'h00;
      rises_q     <= 4'h0;
      cmd_q       <= 8'h00;
      addr_q      <= 32'h0000_0000;
      mode_q      <= 8'h00;
      sh_q        <= 8'h00;
      part_q      <= 2'h0;
      dual_q      <= 1'b0;
      mode_done_q <= 1'b0;
      mode_hit_q  <= 1'b0;
      cont_q      <= 1'b0;
      out_q       <= 4'h0;
      oe_q        <= 4'h0;
      maddr_q     <= '0;
    end else begin
      state_q     <= state_d;
      cnt_q       <= cnt_d;
      addr_len_q  <= addr_len_d;
      left_q      <= left_d;
      rises_q     <= rises_d;
      cmd_q       <= cmd_d;
      addr_q      <= addr_d;
      mode_q      <= mode_d;
      sh_q        <= sh_d;
      part_q      <= part_d;
      dual_q      <= dual_d;
      mode_done_q <= mode_done_d;
      mode_hit_q  <= mode_hit_d;
      cont_q      <= cont_d;
      out_q       <= out_d;
      oe_q        <= oe_d;
      maddr_q     <= maddr_d;
    end
  end

  assign io_out            = out_q;
  assign io_oe             = oe_q;
  assign mem_addr          = maddr_q;
  assign continuous_active = cont_q;

endmodule

/* qodr_pkg.sv */
// constants, states and latency lookup for the quad-output / dual-io read slave
// assumes one 25 MHz system clock; the serial clock is sampled as a plain input
// Notes on behaviour
// R1 - 6Bh quad read, 3/4-byte address; 6Ch 4-byte
// R2 - quad data: one nibble per falling edge
// R3 - dummy cycles follow quad address; inputs ignored
// R4 - address increments per byte, wraps to zero
// R5 - quad read needs quad-enable bit set
// R6 - BBh dual read, 3/4-byte address; BCh 4-byte
// R7 - dual address: two bits per rising edge
// R8 - high-performance variant: no mode cycles
// R9 - enhanced variant: four mode cycles before latency
// R10 - mode Ax keeps continuous dual read
// R11 - other mode value leaves continuous at deselect
// R12 - short invalid select leaves continuous dual read
// R13 - host floats io by first data fall
// R14 - dual data: two bits per falling edge
// R15 - host keeps select low through mode/dummy
// R16 - dual dummy count follows latency code
// R17 - instruction shifted one bit per rising edge
// R18 - extended-address bit widens legacy opcodes
// R19 - raising select ends the read
// R20 - quad address one bit per rise, msb first
package qodr_pkg;

  localparam logic [7:0] QUAD_OUTPUT_READ_CMD           = 8'h6B;
  localparam logic [7:0] QUAD_OUTPUT_READ_WIDE_ADDR_CMD = 8'h6C;
  localparam logic [7:0] DUAL_IO_READ_CMD               = 8'hBB;
  localparam logic [7:0] DUAL_IO_READ_WIDE_ADDR_CMD     = 8'hBC;

  localparam int          MEM_ADDR_W       = 26;
  localparam logic [5:0]  CMD_BITS         = 6'h08;
  localparam logic [5:0]  ADDR_BITS_NARROW = 6'h18;
  localparam logic [5:0]  ADDR_BITS_WIDE   = 6'h20;
  localparam logic [5:0]  MODE_CYCLES      = 6'h04;
  localparam logic [3:0]  CONT_NIBBLE      = 4'hA;
  localparam logic [3:0]  SHORT_SELECT_MAX = 4'h8;
  localparam logic [3:0]  RISE_COUNT_SAT   = 4'hF;

  // dummy cycles per latency code; plain defaults, tune to the part
  localparam logic [5:0]  DUMMY_CODE0 = 6'h04;
  localparam logic [5:0]  DUMMY_CODE1 = 6'h04;
  localparam logic [5:0]  DUMMY_CODE2 = 6'h05;
  localparam logic [5:0]  DUMMY_CODE3 = 6'h00;

  localparam logic [3:0]  OE_QUAD = 4'hF;
  localparam logic [3:0]  OE_DUAL = 4'h3;
  localparam logic [3:0]  OE_NONE = 4'h0;

  typedef enum logic [2:0] {
    QODR_IDLE,
    QODR_CMD,
    QODR_ADDR,
    QODR_MODE,
    QODR_DUMMY,
    QODR_DATA,
    QODR_IGNORE
  } qodr_state_t;

  // latency cycles; with mode cycles present they count toward it
  function automatic logic [5:0] qodr_dummy(input logic [1:0] code, input logic with_mode);
    logic [5:0] lat;
    lat = DUMMY_CODE0;
    case (code)
      2'h1:    lat = DUMMY_CODE1;
      2'h2:    lat = DUMMY_CODE2;
      2'h3:    lat = DUMMY_CODE3;
      default: lat = DUMMY_CODE0;
    endcase
    if (with_mode) begin
      lat = (lat > MODE_CYCLES) ? lat - MODE_CYCLES : 6'h00;
    end
    return lat;
  endfunction

endpackage

/* qodr_sync.sv */
// two-flop synchronisers for serial clock, select and io; edge finders for serial clock and select
// assumes the serial link runs well below a quarter of clk
`timescale 1ns/1ps
module qodr_sync (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       sck,
  input  wire logic       cs_n,
  input  wire logic [3:0] io_in,
  output logic            sck_rise,
  output logic            sck_fall,
  output logic            cs_rise,
  output logic            cs_fall,
  output logic [3:0]      io_s
);

  logic [5:0] meta_q, meta_d;
  logic [5:0] sync_q, sync_d;
  logic [1:0] last_q, last_d;
  logic [3:0] edge_q, edge_d;

  // first stage feeds only the second; edges come from stage two vs its copy
  always_comb begin
    meta_d = {sck, cs_n, io_in};
    sync_d = meta_q;
    last_d = sync_q[5:4];
    edge_d = {sync_q[5] & ~last_q[1], ~sync_q[5] & last_q[1],
              sync_q[4] & ~last_q[0], ~sync_q[4] & last_q[0]};
  end

  // select idles high so no false falling edge after reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= 6'h30;
      sync_q <= 6'h30;
      last_q <= 2'h3;
      edge_q <= 4'h0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      last_q <= last_d;
      edge_q <= edge_d;
    end
  end

  assign sck_rise = edge_q[3];
  assign sck_fall = edge_q[2];
  assign cs_rise  = edge_q[1];
  assign cs_fall  = edge_q[0];
  assign io_s     = sync_q[3:0];

endmodule

/* qodr_read_assertions.sv */
// concurrent checks on the read slave's ports
// assumes a single clk domain with reset_n as its reset
`timescale 1ns/1ps
module qodr_read_assertions (
  input wire logic                       clk,
  input wire logic                       reset_n,
  input wire logic                       sck,
  input wire logic                       cs_n,
  input wire logic [3:0]                 io_out,
  input wire logic [3:0]                 io_oe,
  input wire logic                       quad_enable,
  input wire logic [qodr_pkg::MEM_ADDR_W-1:0] mem_addr,
  input wire logic                       continuous_active
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (!reset_n);
  // only whole-lane patterns may ever be driven
  oe_legal_a: assert property (io_oe inside {4'h0, 4'h3, 4'hF})
    else $error("io enable pattern illegal");
  quad_gate_a: assert property (io_oe == qodr_pkg::OE_QUAD |-> quad_enable)
    else $error("quad drive without quad enable");
  // data moves only after a falling serial clock
  out_fall_a: assert property (io_oe != 4'h0 && $changed(io_out) |-> !$past(sck, 2))
    else $error("io data changed off a falling edge");
  oe_start_a: assert property ($rose(io_oe != 4'h0) |-> !$past(cs_n, 4) && !$past(sck, 2))
    else $error("drive began outside a falling edge");
  oe_drop_a: assert property ($past(io_oe) != 4'h0 && io_oe == 4'h0 |-> $past(cs_n, 2))
    else $error("drive released while selected");
  desel_quiet_a: assert property (cs_n [*8] |-> io_oe == 4'h0)
    else $error("drive while deselected");
  addr_step_a: assert property (io_oe != 4'h0 && $past(io_oe) != 4'h0 && $changed(mem_addr)
    |-> mem_addr - $past(mem_addr) == 26'h1)
    else $error("read address did not step by one");
  cont_exit_a: assert property ($fell(continuous_active) |-> $past(cs_n, 2))
    else $error("continuous mode left while selected");
  cover property (io_oe == qodr_pkg::OE_QUAD);
  cover property (io_oe == qodr_pkg::OE_DUAL);
  cover property ($fell(continuous_active));
endmodule

bind qodr_read qodr_read_assertions qodr_read_assertions_i (.clk, .reset_n, .sck, .cs_n,
  .io_out, .io_oe, .quad_enable, .mem_addr, .continuous_active);

/* qodr_host.sv */
// host model: drives serial clock, select and io lines of the read slave
// assumes clk is the slave clock; a serial cycle is 8 clk, clock idles high
`timescale 1ns/1ps
module qodr_host (
  input  wire logic       clk,
  input  wire logic [3:0] io_out,
  input  wire logic [3:0] io_oe,
  output logic            sck,
  output logic            cs_n,
  output logic [3:0]      io_in
);
  logic       sck_q     = 1'h1;
  logic       cs_n_q    = 1'h1;
  logic       cs_last_q = 1'h1;
  logic [3:0] drv_q     = 4'h0;
  logic [3:0] hoe_q     = 4'h0;
  logic [3:0] junk_q    = 4'h5;
  logic [3:0] rd;
  logic       oe_seen   = 1'h0;
  // link pins come from registers only the tasks write
  assign sck  = sck_q;
  assign cs_n = cs_n_q;
  // released lines toggle so stale data never passes for valid
  assign io_in = (io_oe & io_out) | (~io_oe & hoe_q & drv_q) | (~io_oe & ~hoe_q & junk_q);
  // a new select clears the drive memory; it is read after deselect
  always @(posedge clk) begin
    junk_q <= ~junk_q;
    cs_last_q <= cs_n_q;
    if (!cs_n_q && cs_last_q) oe_seen <= 1'h0;
    else if (io_oe != 4'h0) oe_seen <= 1'h1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // new data at the fall, device samples at the rise, read late in the cycle
  task automatic cyc(input logic [3:0] d, input logic [3:0] oe);
    sck_q <= 1'h0;
    drv_q <= d;
    hoe_q <= oe;
    tick(4);
    sck_q <= 1'h1;
    tick(3);
    rd = io_in;
    tick(1);
  endtask
  task automatic start();
    cs_n_q <= 1'h0;
    tick(2);
  endtask
  // select rises only after a rise, never inside mode or dummy cycles
  task automatic stop();
    cs_n_q <= 1'h1;
    hoe_q <= 4'h0;
    tick(10);
  endtask
  // n cycles of a left-aligned value, w bits a cycle, msb first
  task automatic send(input logic [31:0] v, input int n, input int w);
    for (int i = 0; i < n; i++) begin
      if (w == 1) cyc({3'h0, v[31]}, 4'h1);
      else cyc({2'h0, v[31:30]}, 4'h3);
      v = v << w;
    end
  endtask
  task automatic idle(input int n);
    for (int i = 0; i < n; i++) cyc(4'h0, 4'h0);
  endtask
  task automatic get(input int w, output logic [7:0] b);
    for (int i = 0; i < 8 / w; i++) begin
      cyc(4'h0, 4'h0);
      b = (w == 4) ? {b[3:0], rd} : {b[5:0], rd[1:0]};
    end
  endtask
endmodule

/* testbench.sv */
// self-checking bench for the quad-output / dual-io read slave
// assumes the host model drives the link and a byte pattern answers mem_addr
`timescale 1ns/1ps
module testbench;
  logic        clk;
  logic        reset_n;
  logic        sck;
  logic        cs_n;
  logic [3:0]  io_in;
  logic [3:0]  io_out;
  logic [3:0]  io_oe;
  logic        quad_enable;
  logic [1:0]  latency_code;
  logic        extended_address_enable;
  logic        high_perf_variant;
  logic [25:0] mem_addr;
  logic [7:0]  mem_data = 8'h00;
  logic        continuous_active;
  int          fail_count;
  int          total_checks;
  qodr_read qodr_read_i (.clk, .reset_n, .sck, .cs_n, .io_in, .io_out, .io_oe, .quad_enable,
    .latency_code, .extended_address_enable, .high_perf_variant, .mem_addr, .mem_data,
    .continuous_active);
  qodr_host qodr_host_i (.clk, .io_out, .io_oe, .sck, .cs_n, .io_in);
  always #20 clk = ~clk;
  // upper address bits fold into the byte so a wrong high address shows
  always @(posedge clk) mem_data <= mem_addr[7:0] ^ mem_addr[25:18];
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  function automatic int lat(input logic [1:0] c);
    case (c)
      2'h0: return int'(qodr_pkg::DUMMY_CODE0);
      2'h1: return int'(qodr_pkg::DUMMY_CODE1);
      2'h2: return int'(qodr_pkg::DUMMY_CODE2);
      default: return int'(qodr_pkg::DUMMY_CODE3);
    endcase
  endfunction
  // one read frame; opcode 00 means a continuous frame without instruction
  task automatic rd_frame(input logic [7:0] cmd, input logic [31:0] a, input int ab,
    input int w, input int nm, input logic [7:0] md, input int nd, input int nb);
    logic [7:0]  b;
    logic [25:0] x;
    x = (ab == 24) ? {2'h0, a[23:0]} : a[25:0];
    qodr_host_i.start();
    if (cmd != 8'h00) qodr_host_i.send({cmd, 24'h0}, 8, 1);
    qodr_host_i.send(a << (32 - ab), ab * w / 4, 4 / w);
    qodr_host_i.send({md, 24'h0}, nm, 2);
    qodr_host_i.idle(nd);
    for (int k = 0; k < nb; k++) begin
      qodr_host_i.get(w, b);
      check("read byte", 32'(b), 32'(x[7:0] ^ x[25:18]));
      x = x + 26'h1;
    end
    qodr_host_i.stop();
  endtask
  task automatic t_quad();
    for (int i = 0; i < 4; i++) begin
      quad_enable <= 1'h1;
      latency_code <= 2'(i);
      extended_address_enable <= i[0];
      @(posedge clk);
      rd_frame(i > 1 ? 8'h6C : 8'h6B, 32'hFFFF_FFFE, i == 0 ? 24 : 32, 4, 0, 8'h00,
        lat(2'(i)), 3);
    end
  endtask
  task automatic t_refuse();
    quad_enable <= 1'h0;
    @(posedge clk);
    qodr_host_i.start();
    qodr_host_i.send({8'h6B, 24'h0}, 8, 1);
    qodr_host_i.send(32'h0, 24, 1);
    qodr_host_i.idle(8);
    qodr_host_i.stop();
    check("refused drive", 32'(qodr_host_i.oe_seen), 32'h0);
    // an opcode outside the read set is ignored until deselect
    quad_enable <= 1'h1;
    qodr_host_i.start();
    qodr_host_i.send({8'h3C, 24'h0}, 8, 1);
    qodr_host_i.idle(40);
    qodr_host_i.stop();
    check("unknown opcode drive", 32'(qodr_host_i.oe_seen), 32'h0);
  endtask
  task automatic t_dual();
    int m;
    m = lat(2'h2) > 4 ? lat(2'h2) - 4 : 0;
    high_perf_variant <= 1'h0;
    latency_code <= 2'h2;
    extended_address_enable <= 1'h0;
    @(posedge clk);
    rd_frame(8'hBB, 32'h0012_3456, 24, 2, 4, 8'hA5, m, 2);
    check("cont on", 32'(continuous_active), 32'h1);
    rd_frame(8'h00, 32'h0000_ABCD, 24, 2, 4, 8'h5A, m, 2);
    check("cont off", 32'(continuous_active), 32'h0);
    rd_frame(8'hBC, 32'h0300_0000, 32, 2, 4, 8'hAF, m, 1);
    check("cont again", 32'(continuous_active), 32'h1);
    qodr_host_i.start();
    qodr_host_i.send(32'h0, 4, 2);
    qodr_host_i.stop();
    check("short exit", 32'(continuous_active), 32'h0);
    high_perf_variant <= 1'h1;
    latency_code <= 2'h3;
    extended_address_enable <= 1'h1;
    @(posedge clk);
    rd_frame(8'hBB, 32'h03FF_FFFF, 32, 2, 0, 8'h00, lat(2'h3), 2);
    check("no mode", 32'(continuous_active), 32'h0);
  endtask
  // watchdog: a hang counts as a mismatch
  initial begin
    repeat (100000) @(posedge clk);
    fail_count++;
    conclude();
  end
  initial begin
    clk = 1'h0;
    reset_n = 1'h0;
    quad_enable = 1'h0;
    latency_code = 2'h0;
    extended_address_enable = 1'h0;
    high_perf_variant = 1'h0;
    fail_count = 0;
    total_checks = 0;
    repeat (2) @(posedge clk);
    reset_n <= 1'h1;
    repeat (4) @(posedge clk);
    t_quad();
    t_refuse();
    t_dual();
    conclude();
  end
endmodule
